// File: design/a20_pkg.sv
// shared constants, types and bus carriers of the gate and reset block
package a20_pkg;
   // host i/o map
   localparam logic [15:0] PORT92_ADDR    = 16'h0092;
   localparam logic [15:0] KBD_DATA_OFS   = 16'h0000;
   localparam logic [15:0] KBD_CMD_OFS    = 16'h0004;
   localparam logic [7:0]  PORT92_RST_VAL = 8'h00;
   localparam int          P92_RESET_BIT  = 0;
   localparam int          P92_GATE_BIT   = 1;
   // keyboard command codes seen by the sequence decoder
   localparam logic [7:0]  CMD_GATE       = 8'hd1;
   localparam logic [7:0]  CMD_NOP        = 8'hff;
   localparam logic [7:0]  CMD_PULSE      = 8'hfe;
   localparam int          DATA_GATE_BIT  = 1;
   // firmware register offsets
   localparam logic [11:0] FW_GATE_OFS    = 12'h100;
   localparam logic [11:0] FW_SET_OFS     = 12'h104;
   localparam logic [11:0] FW_CLR_OFS     = 12'h108;
   localparam logic [11:0] FW_CTRL_OFS    = 12'h10c;
   localparam int          CTRL_OVR_BIT   = 0;
   localparam int          CTRL_P92EN_BIT = 1;
   // configuration offsets
   localparam logic [7:0]  CFG_ACT_OFS    = 8'h30;
   localparam logic [7:0]  CFG_BAR_OFS    = 8'h60;
   localparam int          ACT_BIT        = 0;
   localparam int          BAR_VALID_BIT  = 0;
   // timing: 1 us tick derived from the 40 ns system clock
   localparam int          CLK_PERIOD_NS  = 40;
   localparam int          TICK_PERIOD_NS = 1000;
   localparam int          TICK_DIV       = TICK_PERIOD_NS / CLK_PERIOD_NS;
   localparam int          PULSE_US       = 8;
   localparam int          PULSE_TICKS    = PULSE_US * 1000 / TICK_PERIOD_NS;

   typedef enum logic [1:0] {
      SEQ_IDLE = 2'b00,
      SEQ_CMD  = 2'b01,
      SEQ_DATA = 2'b10
   } seq_state_e;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } host_io_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
   } fw_bus_s;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [7:0]  wdata;
   } cfg_bus_s;
endpackage : a20_pkg

// File: design/gate_seq.sv
// command and data sequence decoder that drives the host gate latch
`timescale 1ns/1ps
`default_nettype none
module gate_seq (
   input  wire logic       ref_clk,
   input  wire logic       srst_n,
   input  wire logic       cmd_wr,
   input  wire logic       data_wr,
   input  wire logic [7:0] wdata,
   output logic            latch_we_q,
   output logic            latch_val_q,
   output logic            ibf_set_q
);
   import a20_pkg::*;

   seq_state_e state_q, state_d;
   logic       latch_we_d, ibf_set_d;
   wire        is_gate = (wdata == CMD_GATE);
   wire        is_quiet = is_gate || wdata == CMD_NOP || wdata == CMD_PULSE;

   // next state; quiet codes never reach the keyboard path
   always_comb begin
      state_d    = state_q;
      latch_we_d = 1'b0;
      ibf_set_d  = 1'b0;
      unique case (state_q)
         SEQ_IDLE: begin
            if (cmd_wr && is_gate) state_d = SEQ_CMD;
            else if (cmd_wr) ibf_set_d = !is_quiet;
            else if (data_wr) ibf_set_d = 1'b1;
         end
         SEQ_CMD: begin
            if (data_wr) begin
               latch_we_d = 1'b1;
               state_d    = SEQ_DATA;
            end else if (cmd_wr && !is_gate) begin
               // quiet codes stay silent even when they break a sequence
               ibf_set_d = !is_quiet;
               state_d   = SEQ_IDLE;
            end
         end
         SEQ_DATA: begin
            if (cmd_wr && is_gate) state_d = SEQ_CMD;
            else if (cmd_wr) begin
               ibf_set_d = !is_quiet;
               state_d   = SEQ_IDLE;
            end else if (data_wr) begin
               ibf_set_d = 1'b1;
               state_d   = SEQ_IDLE;
            end
         end
         default: state_d = SEQ_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!srst_n) begin
         state_q     <= SEQ_IDLE;
         latch_we_q  <= 1'b0;
         latch_val_q <= 1'b0;
         ibf_set_q   <= 1'b0;
      end else begin
         state_q     <= state_d;
         latch_we_q  <= latch_we_d;
         latch_val_q <= wdata[DATA_GATE_BIT];
         ibf_set_q   <= ibf_set_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!srst_n);

   AST_SEQ_DATA_BIT:
      assert property (state_q == SEQ_CMD && data_wr |=>
         latch_we_q && !ibf_set_q && latch_val_q == $past(wdata[1]))
      else $error("gate data byte not copied");
   AST_SEQ_QUIET:
      assert property (cmd_wr && is_quiet |=> !ibf_set_q)
      else $error("quiet command raised buffer full");
   AST_SEQ_INVALID:
      assert property (state_q == SEQ_CMD && cmd_wr && !is_quiet |=>
         ibf_set_q && !latch_we_q && state_q == SEQ_IDLE)
      else $error("invalid sequence not flagged");
   AST_SEQ_REPEAT:
      assert property (state_q == SEQ_DATA && cmd_wr && is_gate |=>
         state_q == SEQ_CMD)
      else $error("repeated gate command not accepted");
   AST_SEQ_EXTRA:
      assert property (state_q == SEQ_DATA && data_wr && !cmd_wr |=>
         ibf_set_q && state_q == SEQ_IDLE)
      else $error("extra data byte not flagged");
endmodule : gate_seq
`default_nettype wire

// File: design/reset_pulse.sv
// 1 us timebase and alternate cpu reset pulse generator
`timescale 1ns/1ps
`default_nettype none
module reset_pulse #(
   parameter int TICK_DIV    = a20_pkg::TICK_DIV,
   parameter int PULSE_TICKS = a20_pkg::PULSE_TICKS
) (
   input  wire logic ref_clk,
   input  wire logic srst_n,
   input  wire logic run,
   input  wire logic trig_bit,
   output logic      pulse_n_q
);
   import a20_pkg::*;

   localparam int DW = $clog2(TICK_DIV);
   localparam int CW = $clog2(PULSE_TICKS + 1);
   localparam logic [DW-1:0] DIV_LAST = DW'(TICK_DIV - 1);
   localparam logic [CW-1:0] CNT_LOAD = CW'(PULSE_TICKS);

   if (TICK_DIV < 2 || PULSE_TICKS < 1) begin : g_bad
      $error("reset_pulse needs TICK_DIV >= 2 and PULSE_TICKS >= 1");
   end

   logic [DW-1:0] div_q;
   logic [CW-1:0] cnt_q, cnt_d;
   logic          prev_q;
   wire           tick  = run && div_q == DIV_LAST;
   wire           rise  = trig_bit && !prev_q;
   wire           busy  = cnt_q != '0;

   // a rise while busy is dropped, so no second pulse follows
   always_comb begin
      cnt_d = cnt_q;
      if (rise && !busy) cnt_d = CNT_LOAD;
      else if (busy && tick) cnt_d = cnt_q - 1'b1;
   end

   // divider halts while the block sleeps or is not active
   always_ff @(posedge ref_clk) begin
      if (!srst_n) begin
         div_q     <= '0;
         cnt_q     <= '0;
         prev_q    <= 1'b0;
         pulse_n_q <= 1'b1;
      end else begin
         if (run) div_q <= tick ? '0 : div_q + 1'b1;
         cnt_q     <= cnt_d;
         prev_q    <= trig_bit;
         pulse_n_q <= cnt_d == '0;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!srst_n);

   AST_PULSE_START:
      assert property (rise && !busy |=> !pulse_n_q && cnt_q == CNT_LOAD)
      else $error("reset pulse not launched");
   AST_PULSE_NO_RETRIG:
      assert property (rise && busy |=> cnt_q <= $past(cnt_q))
      else $error("pulse restarted while running");
   AST_TICK_HALT:
      assert property (!run |=> div_q == $past(div_q))
      else $error("timebase ran while halted");
endmodule : reset_pulse
`default_nettype wire

// File: design/legacy_a20_gate_cpu_reset.sv
// legacy port 92h, address line 20 gate and fast cpu reset block
// Function
// - host writes to 92h load the legacy port; legacy reset clears it to 00h
// - port disabled means 92h writes ignored and reads leave bus undriven
// - legacy port base register holds only a writable valid bit
// - override enable selects the firmware gate bit for the gate output
// - firmware read at 100h returns the present gate output
// - data byte after gate command copies its bit 1 into host latch
// - recognised gate sequence raises no buffer-full flag or output interrupt
// - commands FF, FE and D1 never set input buffer full
// - non gate command after gate command is invalid, flags buffer full unless it is FF or FE
// - gate command while awaiting data returns to command-received state
// - extra data byte flags buffer full and returns to idle
// - any write to set or clear strobe sets or clears host latch
// - cpu reset is NAND of alternate and keyboard reset pulses
// - new alternate pulse only after the reset bit was cleared
// - bit cleared and set during a pulse gives no extra pulse
// - timebase stops while sleep requested or block not active
// - activate bit at 30h bit 0, reset by power loss, rest read zero
// - legacy reset on standby reset, power good low or bus reset
// - write at 04h marks command, at 0h marks data
// - 1 MHz tick is the timebase of the reset pulse counter
`timescale 1ns/1ps
`default_nettype none
module legacy_a20_gate_cpu_reset #(
   parameter logic [15:0] KBD_BASE = 16'h0060
) (
   input  wire logic              ref_clk,
   input  wire logic              rst_n,
   input  wire a20_pkg::host_io_s host_io,
   input  wire a20_pkg::fw_bus_s  fw_bus,
   input  wire a20_pkg::cfg_bus_s cfg_bus,
   input  wire logic              main_power_good,
   input  wire logic              lpc_reset_n,
   input  wire logic              block_sleep_request,
   input  wire logic              keyboard_reset_pulse_n,
   output logic [7:0]             host_rdata,
   output logic                   host_rdata_oe_n,
   output logic [7:0]             fw_rdata,
   output logic [7:0]             cfg_rdata,
   output logic                   addr_line_gate_out,
   output logic                   cpu_reset,
   output logic                   legacy_io_reset_n,
   output logic                   input_buffer_full_set,
   output logic                   cmd_data_flag
);
   import a20_pkg::*;

   if (KBD_BASE[1:0] != 2'b00 || KBD_BASE == PORT92_ADDR ||
       KBD_BASE + KBD_CMD_OFS == PORT92_ADDR) begin : g_bad_base
      $error("KBD_BASE must be word aligned and clear of port 92h");
   end

   // synchronisers for the power good and bus reset pins
   logic [1:0] pg_sync_q;
   logic [1:0] lr_sync_q;
   logic       leg_ok_q;
   wire        pg_ok = pg_sync_q[1];
   wire        lr_ok = lr_sync_q[1];
   wire        srst_n = rst_n && leg_ok_q;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         pg_sync_q <= 2'b00;
         lr_sync_q <= 2'b00;
      end else begin
         pg_sync_q <= {pg_sync_q[0], main_power_good};
         lr_sync_q <= {lr_sync_q[0], lpc_reset_n};
      end
   end

   // legacy reset follows any of the three sources
   always_ff @(posedge ref_clk) begin
      if (!rst_n) leg_ok_q <= 1'b0;
      else leg_ok_q <= pg_ok && lr_ok;
   end

   // control state
   logic       act_q;
   logic       bar_valid_q;
   logic       override_q;
   logic       fw_gate_q;
   logic       p92_en_q;
   logic [7:0] port92_q;
   logic       latch_q;
   logic       gate_out_q;

   // address decode
   wire dec_en     = p92_en_q && bar_valid_q;
   wire p92_addr   = host_io.addr == PORT92_ADDR;
   wire p92_wr     = host_io.wr && p92_addr && dec_en;
   wire p92_rd     = host_io.rd && p92_addr && dec_en;
   wire kbd_data   = host_io.wr && host_io.addr == KBD_BASE + KBD_DATA_OFS;
   wire kbd_cmd    = host_io.wr && host_io.addr == KBD_BASE + KBD_CMD_OFS;
   wire fw_gate_wr = fw_bus.wr && fw_bus.addr == FW_GATE_OFS;
   wire fw_set_wr  = fw_bus.wr && fw_bus.addr == FW_SET_OFS;
   wire fw_clr_wr  = fw_bus.wr && fw_bus.addr == FW_CLR_OFS;
   wire fw_ctrl_wr = fw_bus.wr && fw_bus.addr == FW_CTRL_OFS;
   wire cfg_act_wr = cfg_bus.wr && cfg_bus.addr == CFG_ACT_OFS;
   wire cfg_bar_wr = cfg_bus.wr && cfg_bus.addr == CFG_BAR_OFS;
   wire alt_bit    = port92_q[P92_RESET_BIT];
   wire alt_gate   = port92_q[P92_GATE_BIT];

   // activate bit survives bus reset; only standby reset or power loss clears it
   always_ff @(posedge ref_clk) begin
      if (!rst_n || !pg_ok) act_q <= 1'b0;
      else if (cfg_act_wr) act_q <= cfg_bus.wdata[ACT_BIT];
   end

   // base register of the legacy port: valid bit is the only storage
   always_ff @(posedge ref_clk) begin
      if (!rst_n) bar_valid_q <= 1'b0;
      else if (cfg_bar_wr) bar_valid_q <= cfg_bus.wdata[BAR_VALID_BIT];
   end

   // configuration read data; reserved bits read zero
   wire [7:0] cfg_rd_d =
      (cfg_bus.addr == CFG_ACT_OFS) ? {7'h00, act_q} :
      (cfg_bus.addr == CFG_BAR_OFS) ? {7'h00, bar_valid_q} :
      8'h00;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) cfg_rdata <= 8'h00;
      else if (cfg_bus.rd) cfg_rdata <= cfg_rd_d;
   end

   // firmware control bits
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         override_q <= 1'b0;
         p92_en_q   <= 1'b0;
         fw_gate_q  <= 1'b0;
      end else begin
         if (fw_ctrl_wr) begin
            override_q <= fw_bus.wdata[CTRL_OVR_BIT];
            p92_en_q   <= fw_bus.wdata[CTRL_P92EN_BIT];
         end
         if (fw_gate_wr) fw_gate_q <= fw_bus.wdata[0];
      end
   end

   // firmware read data; set and clear strobes read zero
   wire [7:0] fw_rd_d =
      (fw_bus.addr == FW_GATE_OFS) ? {7'h00, gate_out_q} :
      (fw_bus.addr == FW_CTRL_OFS) ? {6'h00, p92_en_q, override_q} :
      8'h00;

   always_ff @(posedge ref_clk) begin
      if (!rst_n) fw_rdata <= 8'h00;
      else if (fw_bus.rd) fw_rdata <= fw_rd_d;
   end

   // legacy port register
   always_ff @(posedge ref_clk) begin
      if (!srst_n) port92_q <= PORT92_RST_VAL;
      else if (p92_wr) port92_q <= host_io.wdata;
   end

   // host read of port 92h; bus left undriven when not decoded
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         host_rdata      <= 8'h00;
         host_rdata_oe_n <= 1'b1;
      end else begin
         host_rdata      <= p92_rd ? port92_q : 8'h00;
         host_rdata_oe_n <= !p92_rd;
      end
   end

   // keyboard command and data sequence decoder
   logic seq_we;
   logic seq_val;
   logic seq_ibf;

   gate_seq u_seq (
      .ref_clk     (ref_clk),
      .srst_n      (srst_n),
      .cmd_wr      (kbd_cmd),
      .data_wr     (kbd_data && !kbd_cmd),
      .wdata       (host_io.wdata),
      .latch_we_q  (seq_we),
      .latch_val_q (seq_val),
      .ibf_set_q   (seq_ibf)
   );

   // host latch; firmware strobes win over the sequence in a tie
   always_ff @(posedge ref_clk) begin
      if (!srst_n) latch_q <= 1'b0;
      else if (fw_set_wr) latch_q <= 1'b1;
      else if (fw_clr_wr) latch_q <= 1'b0;
      else if (seq_we) latch_q <= seq_val;
   end

   // gate output select; one cycle behind the source registers
   wire gate_d = override_q ? fw_gate_q : (latch_q || alt_gate);

   always_ff @(posedge ref_clk) begin
      if (!rst_n) gate_out_q <= 1'b0;
      else gate_out_q <= gate_d;
   end

   // keyboard path strobes; the command flag marks the latest byte
   always_ff @(posedge ref_clk) begin
      if (!srst_n) begin
         cmd_data_flag         <= 1'b0;
         input_buffer_full_set <= 1'b0;
      end else begin
         if (kbd_cmd) cmd_data_flag <= 1'b1;
         else if (kbd_data) cmd_data_flag <= 1'b0;
         input_buffer_full_set <= seq_ibf;
      end
   end

   // alternate reset pulse on the 1 us timebase
   logic alt_pulse_n;

   reset_pulse #(
      .TICK_DIV    (TICK_DIV),
      .PULSE_TICKS (PULSE_TICKS)
   ) u_pulse (
      .ref_clk   (ref_clk),
      .srst_n    (srst_n),
      .run       (act_q && !block_sleep_request),
      .trig_bit  (alt_bit),
      .pulse_n_q (alt_pulse_n)
   );

   // registered outputs
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         cpu_reset         <= 1'b0;
         legacy_io_reset_n <= 1'b0;
      end else begin
         cpu_reset         <= !(alt_pulse_n && keyboard_reset_pulse_n);
         legacy_io_reset_n <= leg_ok_q;
      end
   end

   assign addr_line_gate_out = gate_out_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   AST_P92_RESET:
      assert property (!leg_ok_q |=> port92_q == PORT92_RST_VAL)
      else $error("legacy port not cleared by legacy reset");
   AST_P92_WRITE:
      assert property (p92_wr && leg_ok_q |=>
         port92_q == $past(host_io.wdata))
      else $error("legacy port write lost");
   AST_P92_IGNORE:
      assert property (host_io.wr && p92_addr && !dec_en && leg_ok_q |=>
         port92_q == $past(port92_q))
      else $error("disabled legacy port took a write");
   AST_P92_FLOAT:
      assert property (host_io.rd && p92_addr && !dec_en |=>
         host_rdata_oe_n)
      else $error("disabled legacy port drove the bus");
   AST_BAR_ONE_BIT:
      assert property (cfg_bus.rd && cfg_bus.addr == CFG_BAR_OFS |=>
         cfg_rdata[7:1] == 7'h00)
      else $error("base register shows more than the valid bit");
   AST_OVERRIDE_GATE:
      assert property (override_q |=> addr_line_gate_out == $past(fw_gate_q))
      else $error("override did not select firmware gate bit");
   AST_GATE_READBACK:
      assert property (fw_bus.rd && fw_bus.addr == FW_GATE_OFS |=>
         fw_rdata[0] == $past(addr_line_gate_out))
      else $error("gate readback differs from output");
   AST_LATCH_SET:
      assert property (fw_set_wr && srst_n |=> latch_q)
      else $error("set strobe did not set latch");
   AST_LATCH_CLR:
      assert property (fw_clr_wr && !fw_set_wr && srst_n |=> !latch_q)
      else $error("clear strobe did not clear latch");
   AST_CPU_NAND:
      assert property (##1 cpu_reset ==
         !($past(alt_pulse_n) && $past(keyboard_reset_pulse_n)))
      else $error("cpu reset is not the NAND of both pulses");
   AST_ACT_POWER:
      assert property (!pg_ok |=> !act_q && cfg_rd_d[7:1] == 7'h00)
      else $error("activate bit survived power loss");
   AST_LEGACY_SRC:
      assert property (!pg_ok || !lr_ok |=> ##1 !legacy_io_reset_n)
      else $error("legacy reset not raised");
   AST_CMD_FLAG:
      assert property (kbd_cmd && srst_n |=> cmd_data_flag)
      else $error("command write not marked");
   AST_OR_GATE:
      assert property (!override_q |=>
         addr_line_gate_out == ($past(latch_q) || $past(alt_gate)))
      else $error("gate is not latch OR legacy gate bit");

   COV_GATE_ON: cover property (seq_we && seq_val ##1 latch_q);
   COV_ALT_PULSE: cover property ($fell(alt_pulse_n) ##[1:300] cpu_reset);
   COV_INVALID: cover property (seq_ibf && !seq_we);
   COV_P92_READ: cover property (!host_rdata_oe_n);
endmodule : legacy_a20_gate_cpu_reset
`default_nettype wire

// File: test/host_model.sv
// host chipset model issuing single-cycle lpc i/o writes and reads
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input  wire logic          ref_clk,
   output var a20_pkg::host_io_s io
);
   import a20_pkg::*;
   initial io = '0;
   // one request per call, released with inverted address and data
   task automatic cyc(input logic w, input logic [15:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      io = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      io = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask : cyc
endmodule : host_model
`default_nettype wire

// File: test/test_legacy_a20_gate_cpu_reset.sv
// self-checking bench with reference model of gate and reset logic
`timescale 1ns/1ps
`default_nettype none
module test_legacy_a20_gate_cpu_reset;
   import a20_pkg::*;
   localparam logic [15:0] KB = 16'h0060;
   localparam int          W  = PULSE_TICKS * TICK_DIV;
   logic       ref_clk, rst_n, pg, lrst_n, sleep, kres_n;
   logic       oe_n, gate, cpu_reset, lio_n, input_buffer_full, cd;
   logic [7:0] host_rdata, fw_rdata, cfg_rdata, v;
   logic [8:0] seq [22];
   host_io_s   host_io;
   fw_bus_s    fw;
   cfg_bus_s   cfg;
   int         n_mismatch, checks_done, cyc_n, ibf_n, n;
   int         m_latch, m_p92, m_st, m_ibf, m_ovr, m_fwg;
   integer     seed = 32'he4f0;

   legacy_a20_gate_cpu_reset #(.KBD_BASE(KB)) uut (
      .ref_clk(ref_clk), .rst_n(rst_n), .host_io(host_io),
      .fw_bus(fw), .cfg_bus(cfg), .main_power_good(pg),
      .lpc_reset_n(lrst_n), .block_sleep_request(sleep),
      .keyboard_reset_pulse_n(kres_n), .host_rdata(host_rdata),
      .host_rdata_oe_n(oe_n), .fw_rdata(fw_rdata),
      .cfg_rdata(cfg_rdata), .addr_line_gate_out(gate),
      .cpu_reset(cpu_reset), .legacy_io_reset_n(lio_n),
      .input_buffer_full_set(input_buffer_full), .cmd_data_flag(cd));
   host_model u_host (.ref_clk(ref_clk), .io(host_io));

   // clock
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // buffer-full pulses and hang guard
   always @(posedge ref_clk) begin
      if (input_buffer_full === 1'b1) ibf_n++;
      cyc_n++;
      if (cyc_n == 10000) begin
         n_mismatch++;
         summarize();
      end
   end

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic summarize();
      $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
      if (n_mismatch == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : summarize

   function automatic logic [7:0] gexp();
      return (m_ovr != 0) ? 8'(m_fwg) : 8'(m_latch | m_p92[1]);
   endfunction : gexp

   // firmware (k=0) or configuration (k=1) single-cycle access
   task automatic bus(input bit k, input bit w, input logic [11:0] a,
                      input logic [7:0] d);
      @(posedge ref_clk);
      #1;
      if (k) cfg = '{wr: w, rd: !w, addr: a[7:0], wdata: d};
      else fw = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge ref_clk);
      #1;
      fw = '0;
      cfg = '0;
   endtask : bus

   task automatic rd(input bit k, input logic [11:0] a,
                     input logic [7:0] e);
      bus(k, 1'b0, a, 8'h00);
      @(posedge ref_clk);
      chk(k ? cfg_rdata : fw_rdata, e);
   endtask : rd

   task automatic p92(input logic [7:0] d, input bit en);
      u_host.cyc(1'b1, PORT92_ADDR, d);
      if (en) m_p92 = d;
      repeat (3) @(posedge ref_clk);
      chk(gate, gexp());
   endtask : p92

   // keyboard byte with reference sequencer, then compare
   task automatic kbd(input bit c, input logic [7:0] d);
      u_host.cyc(1'b1, KB + (c ? KBD_CMD_OFS : KBD_DATA_OFS), d);
      if (c && d == CMD_GATE) m_st = 1;
      else if (c) begin
         if (d != CMD_NOP && d != CMD_PULSE) m_ibf++;
         m_st = 0;
      end else if (m_st == 1) begin
         m_latch = d[DATA_GATE_BIT];
         m_st = 2;
      end else begin
         m_ibf++;
         m_st = 0;
      end
      repeat (4) @(posedge ref_clk);
      chk(gate, gexp());
      chk(8'(ibf_n), 8'(m_ibf));
      chk(cd, c);
   endtask : kbd

   task automatic pw(output int cnt);
      cnt = 0;
      repeat (600) begin
         @(posedge ref_clk);
         if (cpu_reset === 1'b1) cnt++;
      end
   endtask : pw

   // main sequence; 9'h?aa entries take a random byte
   initial begin
      rst_n = 1'b0; pg = 1'b1; lrst_n = 1'b1; sleep = 1'b0;
      kres_n = 1'b1; fw = '0; cfg = '0;
      seq = '{9'h1d1, 9'h0df, 9'h1ff, 9'h1d1, 9'h0dd, 9'h1ff, 9'h1d1,
              9'h1d1, 9'h0df, 9'h1d1, 9'h1d1, 9'h0dd, 9'h1d1, 9'h1aa,
              9'h1ff, 9'h1d1, 9'h0aa, 9'h0aa, 9'h1fe, 9'h0aa, 9'h1d1, 9'h1ff};
      repeat (8) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      repeat (6) @(posedge ref_clk);
      chk(lio_n, 8'h01);
      rd(1'b1, CFG_ACT_OFS, 8'h00);
      rd(1'b0, FW_CTRL_OFS, 8'h00);
      rd(1'b0, 12'h200, 8'h00);
      bus(1'b1, 1'b1, CFG_BAR_OFS, 8'hff);
      rd(1'b1, CFG_BAR_OFS, 8'h01);
      p92(8'h02, 1'b0);
      u_host.cyc(1'b0, PORT92_ADDR, 8'h00);
      chk(oe_n, 8'h01);
      bus(1'b0, 1'b1, FW_CTRL_OFS, 8'h02);
      p92(8'h02, 1'b1);
      u_host.cyc(1'b0, PORT92_ADDR, 8'h00);
      chk(oe_n, 8'h00);
      chk(host_rdata, 8'h02);
      p92(8'h00, 1'b1);
      foreach (seq[i]) begin
         v = seq[i][7:0];
         if (v == 8'haa) v = 8'($random(seed));
         if (seq[i][7:0] == 8'haa && seq[i][8]) v[7] = 1'b0;
         kbd(seq[i][8], v);
      end
      // strobes and override; readback with override on and off
      v = 8'($random(seed));
      bus(1'b0, 1'b1, FW_SET_OFS, v);
      m_latch = 1;
      rd(1'b0, FW_GATE_OFS, gexp());
      bus(1'b0, 1'b1, FW_GATE_OFS, 8'h01);
      bus(1'b0, 1'b1, FW_CTRL_OFS, 8'h03);
      m_fwg = 1;
      m_ovr = 1;
      v = 8'($random(seed));
      bus(1'b0, 1'b1, FW_CLR_OFS, v);
      m_latch = 0;
      rd(1'b0, FW_GATE_OFS, gexp());
      chk(gate, gexp());
      bus(1'b0, 1'b1, FW_GATE_OFS, 8'h00);
      bus(1'b0, 1'b1, FW_CTRL_OFS, 8'h02);
      m_fwg = 0;
      m_ovr = 0;
      rd(1'b0, FW_GATE_OFS, gexp());
      // alternate and keyboard cpu reset
      bus(1'b1, 1'b1, CFG_ACT_OFS, 8'hff);
      rd(1'b1, CFG_ACT_OFS, 8'h01);
      fork pw(n); p92(8'h01, 1'b1); join
      chk(8'(n >= W - TICK_DIV && n <= W + TICK_DIV), 8'h01);
      fork pw(n); p92(8'h01, 1'b1); join
      chk(8'(n), 8'h00);
      p92(8'h00, 1'b1);
      fork
         pw(n);
         begin
            p92(8'h01, 1'b1);
            repeat (40) @(posedge ref_clk);
            p92(8'h00, 1'b1);
            p92(8'h01, 1'b1);
            #1 sleep = 1'b1;
            repeat (100) @(posedge ref_clk);
            #1 sleep = 1'b0;
         end
      join
      chk(8'(n >= W + 100 - TICK_DIV && n <= W + 100 + TICK_DIV),
          8'h01);
      fork
         pw(n);
         begin
            @(posedge ref_clk);
            #1 kres_n = 1'b0;
            repeat (5) @(posedge ref_clk);
            #1 kres_n = 1'b1;
         end
      join
      chk(8'(n), 8'h05);
      // legacy reset from bus reset and from main power loss
      p92(8'h02, 1'b1);
      #1 lrst_n = 1'b0;
      repeat (10) @(posedge ref_clk);
      chk(lio_n, 8'h00);
      #1 lrst_n = 1'b1;
      m_p92 = 0;
      repeat (10) @(posedge ref_clk);
      chk(gate, gexp());
      p92(8'h02, 1'b1);
      #1 pg = 1'b0;
      repeat (10) @(posedge ref_clk);
      chk(lio_n, 8'h00);
      #1 pg = 1'b1;
      m_p92 = 0;
      repeat (10) @(posedge ref_clk);
      chk(gate, gexp());
      rd(1'b1, CFG_ACT_OFS, 8'h00);
      summarize();
   end
endmodule : test_legacy_a20_gate_cpu_reset
`default_nettype wire
